// File: rtl/scss_clock_select.sv
// Contract
// (R01) reset loads calibration byte into trim
// (R02) trim zero lowest, all ones highest
// (R03) trim top bit picks overlapping range
// (R04) low seven trim bits tune within range
// (R05) memory timing runs from RC oscillator
// (R06) software keeps trim below 8.8 MHz
// (R07) software steps trim by 0x20 at most
// (R08) select code 00 uses external clock
// (R09) external clock start-up delays per code
// (R10) pll source divided by four
// (R11) pll start-up delays per code
// (R12) select code 11 uses 128 kHz oscillator
// (R13) 128 kHz start-up delays per code
// (R14) output setting drives clock on pin
// (R15) no clock out during reset
// (R16) pin carries prescaled system clock
// (R17) one divider feeds all clock domains
// (R18) select code n divides by 2^n
// (R19) change-enable then code within four cycles
// (R20) reset code follows divide-by-eight setting
// (R21) clock gated until counts and delay done
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module scss_clock_select #(
	parameter int DLY_A_CYC = scss_pkg::DLY_A_CYC,
	parameter int DLY_B_CYC = scss_pkg::DLY_B_CYC,
	parameter int DLY_C_CYC = scss_pkg::DLY_C_CYC,
	parameter int DLY_D_CYC = scss_pkg::DLY_D_CYC
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	// nonvolatile settings, caught at reset
	input  wire logic [3:0]  clock_source_select_i,
	input  wire logic [1:0]  startup_time_select_i,
	input  wire logic        clock_output_enable_setting_i,
	input  wire logic        initial_divide_by_eight_i,
	input  wire logic [7:0]  calibration_byte_i,
	// source clock levels
	input  wire logic        external_clock_input_i,
	input  wire logic        pll_clock_i,
	input  wire logic        rc_osc_clock_i,
	input  wire logic        lp_osc_clock_i,
	// power-down request
	input  wire logic        power_down_i,
	// axi4-lite write
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// trim to the rc oscillator
	output logic             trim_range_select_o,
	output logic [6:0]       trim_fine_value_o,
	output logic [7:0]       trim_freq_rank_o,
	// clock domain ticks
	output logic             core_domain_tick_o,
	output logic             io_domain_tick_o,
	output logic             converter_domain_tick_o,
	output logic             program_memory_tick_o,
	output logic             nvm_timing_tick_o,
	output logic             pll_timer_tick_o,
	// clock output pin
	output logic             clock_output_pin_o,
	output logic             clock_output_oe_o
);

	// source edge detection
	logic [3:0] src_level;
	logic [3:0] src_rise;
	logic [3:0] src_in;

	assign src_in = {lp_osc_clock_i, rc_osc_clock_i, pll_clock_i, external_clock_input_i};

	for (genvar g = 0; g < 4; g++) begin : g_edge
		scss_edge_tick u_edge (
			.clock_i (clock_i),
			.rstn_i  (rstn_i),
			.level_i (src_in[g]),
			.level_o (src_level[g]),
			.rise_o  (src_rise[g])
		);
	end

	// settings latch, bus, registers and start-up state
	logic [3:0]                     src_sel,   next_src_sel;
	logic [1:0]                     sut_sel,   next_sut_sel;
	logic                           cko_set,   next_cko_set;
	logic [7:0]                     trim,      next_trim;
	logic [3:0]                     ps_code,   next_ps_code;
	logic                           pce,       next_pce;
	logic [2:0]                     pce_cnt,   next_pce_cnt;
	logic [1:0]                     pll_div,   next_pll_div;
	logic [7:0]                     ps_cnt,    next_ps_cnt;
	scss_pkg::scss_state_t          state,     next_state;
	logic [14:0]                    ck_cnt,    next_ck_cnt;
	logic [14:0]                    ck_target, next_ck_target;
	logic [scss_pkg::MS_CNT_W-1:0]  ms_cnt,    next_ms_cnt;
	logic                           aw_held,   next_aw_held;
	logic [7:0]                     aw_addr,   next_aw_addr;
	logic                           w_held,    next_w_held;
	logic [31:0]                    w_data,    next_w_data;
	logic                           w_lane0,   next_w_lane0;
	logic                           bvalid,    next_bvalid;
	logic [1:0]                     bresp,     next_bresp;
	logic                           rvalid,    next_rvalid;
	logic [31:0]                    rdata,     next_rdata;
	logic [1:0]                     rresp,     next_rresp;
	logic                           clk_out,   next_clk_out;

	logic                           do_write;
	logic                           sut_rsv;
	logic                           src_tick;
	logic                           src_lvl;
	logic [3:0]                     ps_eff;
	logic [7:0]                     ps_mask;
	logic                           div_tick;
	logic                           div_lvl;
	logic                           running;
	logic [31:0]                    status_word;

	// reserved start-up code only exists for the cycle-6 sources
	assign sut_rsv = (src_sel != scss_pkg::SRC_PLL) && (sut_sel == scss_pkg::SUT_3);

	// selected source clock; reserved select codes fall back to the rc oscillator
	always_comb begin
		src_tick = src_rise[2];
		src_lvl  = src_level[2];
		case (src_sel)
			scss_pkg::SRC_EXT: begin
				src_tick = src_rise[0]; // R08
				src_lvl  = src_level[0];
			end
			scss_pkg::SRC_PLL: begin
				src_tick = src_rise[1] && (pll_div == scss_pkg::PLL_DIV_LAST); // R10
				src_lvl  = pll_div[1];
			end
			scss_pkg::SRC_LP: begin
				src_tick = src_rise[3]; // R12
				src_lvl  = src_level[3];
			end
			default: begin
				src_tick = src_rise[2];
				src_lvl  = src_level[2];
			end
		endcase
	end

	// prescaler: reserved codes divide as 256
	assign ps_eff   = (ps_code > scss_pkg::PS_MAX_CODE) ? scss_pkg::PS_MAX_CODE : ps_code; // R18
	assign ps_mask  = 8'((9'h001 << ps_eff) - 9'h001); // R18
	assign div_tick = src_tick && ((ps_cnt & ps_mask) == ps_mask); // R16
	assign div_lvl  = (ps_eff == 4'h0) ? src_lvl : ps_cnt[3'(ps_eff - 4'h1)];
	assign running  = (state == scss_pkg::ST_RUN);

	assign status_word = {24'h000000, src_sel, 1'b0, sut_rsv,
		(state == scss_pkg::ST_SLEEP), running};

	// axi handshake outputs
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready  = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign do_write      = aw_held && w_held && !bvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held  = 1'b1;
			next_w_data  = s_axi_wdata;
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (aw_addr == scss_pkg::ADDR_TRIM || aw_addr == scss_pkg::ADDR_PRESCALE ||
				aw_addr == scss_pkg::ADDR_STATUS) ? scss_pkg::RESP_OKAY : scss_pkg::RESP_SLVERR;
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = scss_pkg::RESP_OKAY;
			case (s_axi_araddr)
				scss_pkg::ADDR_TRIM:     next_rdata = {24'h000000, trim};
				scss_pkg::ADDR_PRESCALE: next_rdata = {24'h000000, pce, 3'h0, ps_code};
				scss_pkg::ADDR_STATUS:   next_rdata = status_word;
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = scss_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// registers, dividers and start-up sequencing
	always_comb begin
		next_src_sel   = src_sel;
		next_sut_sel   = sut_sel;
		next_cko_set   = cko_set;
		next_trim      = trim;
		next_ps_code   = ps_code;
		next_pce       = pce;
		next_pce_cnt   = pce_cnt;
		next_pll_div   = pll_div;
		next_ps_cnt    = ps_cnt;
		next_state     = state;
		next_ck_cnt    = ck_cnt;
		next_ck_target = ck_target;
		next_ms_cnt    = ms_cnt;
		next_clk_out   = 1'b0;

		// change-enable window: not extended by a rewrite
		if (pce) begin
			if (pce_cnt == PCE_TIMEOUT_M1()) begin
				next_pce = 1'b0; // R19
			end
			next_pce_cnt = pce_cnt + 3'h1;
		end
		if (do_write && w_lane0) begin
			case (aw_addr)
				scss_pkg::ADDR_TRIM: next_trim = w_data[7:0];
				scss_pkg::ADDR_PRESCALE: begin
					if (w_data[scss_pkg::PCR_CE_BIT] && w_data[6:0] == scss_pkg::PCR_LOW_ZERO) begin
						if (!pce) begin
							next_pce     = 1'b1; // R19
							next_pce_cnt = 3'h0;
						end
					end else if (!w_data[scss_pkg::PCR_CE_BIT] && pce) begin
						next_ps_code = w_data[3:0]; // R19
						next_pce     = 1'b0;
					end
				end
				default: begin
					next_trim = trim;
				end
			endcase
		end

		if (src_rise[1]) begin
			next_pll_div = pll_div + 2'h1; // R10
		end
		if (src_tick) begin
			next_ps_cnt = ps_cnt + 8'h01; // R17
		end

		case (state)
			scss_pkg::ST_OFF: begin
				// leaving reset: 14 source cycles and the reset delay, counted side by side
				next_state     = scss_pkg::ST_WAIT;
				next_ck_cnt    = 15'h0000;
				next_ck_target = scss_pkg::CK_RESET; // R09 R11 R13
				if (src_sel == scss_pkg::SRC_PLL) begin
					next_ms_cnt = sut_sel[1] ? scss_pkg::MS_CNT_W'(DLY_D_CYC) : scss_pkg::MS_CNT_W'(DLY_B_CYC); // R11
				end else begin
					case (sut_sel)
						scss_pkg::SUT_0: next_ms_cnt = '0; // R09 R13
						scss_pkg::SUT_1: next_ms_cnt = scss_pkg::MS_CNT_W'(DLY_A_CYC);
						default:         next_ms_cnt = scss_pkg::MS_CNT_W'(DLY_C_CYC);
					endcase
				end
			end
			scss_pkg::ST_WAIT: begin
				if (src_tick && ck_cnt != ck_target) begin
					next_ck_cnt = ck_cnt + 15'h0001; // R21
				end
				if (ms_cnt != '0) begin
					next_ms_cnt = ms_cnt - scss_pkg::MS_CNT_W'(1);
				end
				if (ck_cnt == ck_target && ms_cnt == '0) begin
					next_state = scss_pkg::ST_RUN; // R21
				end
			end
			scss_pkg::ST_RUN: begin
				next_clk_out = div_lvl & cko_set; // R14 R16
				if (power_down_i) begin
					next_state = scss_pkg::ST_SLEEP;
				end
			end
			scss_pkg::ST_SLEEP: begin
				if (!power_down_i) begin
					next_state  = scss_pkg::ST_WAIT;
					next_ck_cnt = 15'h0000;
					next_ms_cnt = '0;
					if (src_sel == scss_pkg::SRC_PLL) begin
						next_ck_target = sut_sel[0] ? scss_pkg::CK_PLL_16K : scss_pkg::CK_PLL_1K; // R11
					end else begin
						next_ck_target = scss_pkg::CK_PD_FAST; // R09 R13
					end
				end
			end
			default: begin
				next_state = scss_pkg::ST_OFF;
			end
		endcase
	end

	function automatic logic [2:0] PCE_TIMEOUT_M1();
		PCE_TIMEOUT_M1 = scss_pkg::PCE_TIMEOUT - 3'h1;
	endfunction : PCE_TIMEOUT_M1

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			// settings are caught while reset is held
			src_sel   <= clock_source_select_i;
			sut_sel   <= startup_time_select_i;
			cko_set   <= clock_output_enable_setting_i;
			trim      <= calibration_byte_i; // R01
			ps_code   <= initial_divide_by_eight_i ? scss_pkg::PS_RESET_DIV8 : scss_pkg::PS_RESET_DIV1; // R20
			pce       <= 1'b0;
			pce_cnt   <= 3'h0;
			pll_div   <= 2'h0;
			ps_cnt    <= 8'h00;
			state     <= scss_pkg::ST_OFF;
			ck_cnt    <= 15'h0000;
			ck_target <= scss_pkg::CK_RESET;
			ms_cnt    <= '0;
			aw_held   <= 1'b0;
			aw_addr   <= 8'h00;
			w_held    <= 1'b0;
			w_data    <= 32'h00000000;
			w_lane0   <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= scss_pkg::RESP_OKAY;
			rvalid    <= 1'b0;
			rdata     <= 32'h00000000;
			rresp     <= scss_pkg::RESP_OKAY;
			clk_out   <= 1'b0; // R15
		end else begin
			src_sel   <= next_src_sel;
			sut_sel   <= next_sut_sel;
			cko_set   <= next_cko_set;
			trim      <= next_trim;
			ps_code   <= next_ps_code;
			pce       <= next_pce;
			pce_cnt   <= next_pce_cnt;
			pll_div   <= next_pll_div;
			ps_cnt    <= next_ps_cnt;
			state     <= next_state;
			ck_cnt    <= next_ck_cnt;
			ck_target <= next_ck_target;
			ms_cnt    <= next_ms_cnt;
			aw_held   <= next_aw_held;
			aw_addr   <= next_aw_addr;
			w_held    <= next_w_held;
			w_data    <= next_w_data;
			w_lane0   <= next_w_lane0;
			bvalid    <= next_bvalid;
			bresp     <= next_bresp;
			rvalid    <= next_rvalid;
			rdata     <= next_rdata;
			rresp     <= next_rresp;
			clk_out   <= next_clk_out;
		end
	end

	// trim outputs; high range overlaps the low one on the rank scale
	assign trim_range_select_o = trim[scss_pkg::TRIM_RANGE_BIT]; // R03
	assign trim_fine_value_o   = trim[6:0]; // R04
	assign trim_freq_rank_o    = trim[scss_pkg::TRIM_RANGE_BIT] ?
		({1'b0, trim[6:0]} + scss_pkg::TRIM_RANGE_OFFSET) : {1'b0, trim[6:0]}; // R02 R03 R04

	// core, io, converter and program memory domains share one divided, gated tick
	assign core_domain_tick_o      = running && div_tick; // R17 R21
	assign io_domain_tick_o        = running && div_tick;
	assign converter_domain_tick_o = running && div_tick;
	assign program_memory_tick_o   = running && div_tick;
	// memory timing ignores the system clock choice
	assign nvm_timing_tick_o       = src_rise[2]; // R05
	assign pll_timer_tick_o        = src_rise[1];

	assign clock_output_pin_o = clk_out;
	assign clock_output_oe_o  = cko_set; // R14

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp  = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata  = rdata;
	assign s_axi_rresp  = rresp;

endmodule : scss_clock_select

`default_nettype wire

// File: rtl/scss_edge_tick.sv
`timescale 1ns/10ps
`default_nettype none

module scss_edge_tick (
	// clock and reset
	input  wire logic clock_i,
	input  wire logic rstn_i,
	// source level, synchronous to clock_i
	input  wire logic level_i,
	// registered level and rising-edge pulse
	output logic      level_o,
	output logic      rise_o
);

	logic level;
	logic next_level;

	always_comb begin
		next_level = level_i;
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			level <= 1'b0;
		end else begin
			level <= next_level;
		end
	end

	assign level_o = level;
	assign rise_o  = level_i & ~level;

endmodule : scss_edge_tick

`default_nettype wire

// File: rtl/scss_pkg.sv
`default_nettype none

package scss_pkg;

	// clock source select codes
	localparam logic [3:0] SRC_EXT = 4'h0;
	localparam logic [3:0] SRC_PLL = 4'h1;
	localparam logic [3:0] SRC_RC  = 4'h2;
	localparam logic [3:0] SRC_LP  = 4'h3;

	// start-up time select codes
	localparam logic [1:0] SUT_0 = 2'h0;
	localparam logic [1:0] SUT_1 = 2'h1;
	localparam logic [1:0] SUT_2 = 2'h2;
	localparam logic [1:0] SUT_3 = 2'h3;

	// start-up cycle counts on the selected source clock
	localparam logic [14:0] CK_RESET   = 15'h000E;
	localparam logic [14:0] CK_PD_FAST = 15'h0006;
	localparam logic [14:0] CK_PLL_1K  = 15'h0400;
	localparam logic [14:0] CK_PLL_16K = 15'h4000;

	// additional reset delays, in ms, and their cycle counts at clock_i
	localparam int CLK_KHZ     = 125000;
	localparam int DLY_A_MS    = 4;
	localparam int DLY_B_MS    = 8;
	localparam int DLY_C_MS    = 64;
	localparam int DLY_D_MS    = 68;
	localparam int DLY_A_CYC   = DLY_A_MS * CLK_KHZ;
	localparam int DLY_B_CYC   = DLY_B_MS * CLK_KHZ;
	localparam int DLY_C_CYC   = DLY_C_MS * CLK_KHZ;
	localparam int DLY_D_CYC   = DLY_D_MS * CLK_KHZ;
	localparam int MS_CNT_W    = 24;

	// pll divide by four: last phase of a two-bit counter
	localparam logic [1:0] PLL_DIV_LAST = 2'h3;

	// trim: overlap offset of the high range on the frequency rank scale
	localparam logic [7:0] TRIM_RANGE_OFFSET = 8'h40;
	localparam int         TRIM_RANGE_BIT    = 7;

	// prescale control register
	localparam int         PCR_CE_BIT     = 7;
	localparam logic [3:0] PS_MAX_CODE    = 4'h8;
	localparam logic [3:0] PS_RESET_DIV1  = 4'h0;
	localparam logic [3:0] PS_RESET_DIV8  = 4'h3;
	localparam logic [2:0] PCE_TIMEOUT    = 3'h4;
	localparam logic [6:0] PCR_LOW_ZERO   = 7'h00;

	// register byte offsets
	localparam logic [7:0] ADDR_TRIM     = 8'h00;
	localparam logic [7:0] ADDR_PRESCALE = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;

	// status register fields
	localparam int ST_RUN_BIT   = 0;
	localparam int ST_SLEEP_BIT = 1;
	localparam int ST_RSV_BIT   = 2;
	localparam int ST_SRC_LSB   = 4;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_WAIT  = 2'b01,
		ST_RUN   = 2'b11,
		ST_SLEEP = 2'b10
	} scss_state_t;

endpackage : scss_pkg

`default_nettype wire

// File: verif/scss_clock_select_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module scss_chk (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       rstn_i,
	// settings
	input wire logic       clock_output_enable_setting_i,
	input wire logic [7:0] calibration_byte_i,
	// register bus
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	// trim
	input wire logic       trim_range_select_o,
	input wire logic [6:0] trim_fine_value_o,
	input wire logic [7:0] trim_freq_rank_o,
	// ticks and pin
	input wire logic       core_domain_tick_o,
	input wire logic       io_domain_tick_o,
	input wire logic       converter_domain_tick_o,
	input wire logic       program_memory_tick_o,
	input wire logic       clock_output_pin_o,
	input wire logic       clock_output_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence

	ticks_aligned_a: assert property (core_domain_tick_o == io_domain_tick_o &&
		io_domain_tick_o == converter_domain_tick_o && converter_domain_tick_o == program_memory_tick_o)
		else $error("domain ticks differ");
	trim_load_a: assert property ($rose(rstn_i) |->
		{trim_range_select_o, trim_fine_value_o} == $past(calibration_byte_i)) else $error("trim not loaded");
	rank_map_a: assert property (trim_freq_rank_o == {1'b0, trim_fine_value_o} +
		(trim_range_select_o ? 8'h40 : 8'h00)) else $error("trim rank wrong");
	oe_capture_a: assert property ($rose(rstn_i) |->
		clock_output_oe_o == $past(clock_output_enable_setting_i)) else $error("pin enable wrong");
	pin_quiet_a: assert property ($rose(rstn_i) |-> !clock_output_pin_o) else $error("pin active in reset");
	startup_gate_a: assert property ($rose(rstn_i) |-> !core_domain_tick_o [*8]) else $error("early tick");
	pin_off_a: assert property (!clock_output_oe_o |-> !clock_output_pin_o) else $error("pin driven");
	wr_answer_a: assert property (wr_taken |=> wr_answer) else $error("write answer late");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not held off");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not held off");
endmodule : scss_chk

bind scss_clock_select scss_chk u_scss_chk (
	.clock_i, .rstn_i, .clock_output_enable_setting_i, .calibration_byte_i,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.trim_range_select_o, .trim_fine_value_o, .trim_freq_rank_o,
	.core_domain_tick_o, .io_domain_tick_o, .converter_domain_tick_o, .program_memory_tick_o,
	.clock_output_pin_o, .clock_output_oe_o
);

`default_nettype wire

// File: verif/test_system_clock_source_select.sv
`timescale 1ns/10ps
`default_nettype none

module test_system_clock_source_select;
	logic        clock_i = 0, rstn_i = 0, pd = 0, oe = 1, div8 = 0;
	logic [3:0]  src = 4'h0, cnt = 4'h0, strb = 4'hF;
	logic [1:0]  startup_time_select = 2'h0, s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rank;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        trs, ct, nt, plt, pin, it, at, mt, oeo;
	logic [6:0]  tfv;
	int          n_errors = 0, total_checks = 0;
	// source, delay code, source period in clock_i cycles, reset delay
	int          ts [8] = '{0, 0, 2, 0, 1, 1, 3, 3};
	int          tu [8] = '{0, 1, 2, 3, 1, 2, 0, 2};
	int          tp [8] = '{4, 4, 8, 4, 16, 16, 16, 16};
	int          td [8] = '{0, 100, 300, 300, 150, 400, 0, 300};
	logic [7:0]  tv [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
	logic [7:0]  tr [4] = '{8'h00, 8'h7F, 8'h40, 8'hBF};
	int          pc [4] = '{1, 2, 8, 9};

	// short ms delays keep the run small
	scss_clock_select #(.DLY_A_CYC(100), .DLY_B_CYC(150), .DLY_C_CYC(300), .DLY_D_CYC(400)) u_scss_clock_select (
		.clock_i, .rstn_i, .clock_source_select_i(src), .startup_time_select_i(startup_time_select),
		.clock_output_enable_setting_i(oe), .initial_divide_by_eight_i(div8), .calibration_byte_i(8'hA5),
		.external_clock_input_i(cnt[1]), .pll_clock_i(cnt[1]), .rc_osc_clock_i(cnt[2]), .lp_osc_clock_i(cnt[3]),
		.power_down_i(pd), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb(strb), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.trim_range_select_o(trs), .trim_fine_value_o(tfv), .trim_freq_rank_o(rank), .core_domain_tick_o(ct),
		.io_domain_tick_o(it), .converter_domain_tick_o(at), .program_memory_tick_o(mt), .nvm_timing_tick_o(nt),
		.pll_timer_tick_o(plt), .clock_output_pin_o(pin), .clock_output_oe_o(oeo)
	);

	initial forever #4 clock_i = ~clock_i;
	always @(posedge clock_i) cnt <= cnt + 4'h1;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict

	task automatic hang;
		n_errors++;
		print_verdict();
	endtask : hang

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
			n_errors++;
		end
	endtask : chk

	// pin enable follows the inverse of divide-by-eight so both pin modes get exercised
	task automatic rst(input logic [3:0] s, input logic [1:0] u, input logic d);
		@(posedge clock_i);
		src <= s;
		startup_time_select <= u;
		div8 <= d;
		oe <= !d;
		rstn_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rstn_i <= 1'b1;
	endtask : rst

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		b = 0;
		@(posedge clock_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int n = 0; n < 40 && !b; n++) begin
			@(negedge clock_i);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clock_i);
			if (aw) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
			if (b) s_axi_bready <= 0;
		end
		if (!b) hang();
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		v = 0;
		@(posedge clock_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int n = 0; n < 40 && !v; n++) begin
			@(negedge clock_i);
			ar = s_axi_arvalid & s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clock_i);
			if (ar) s_axi_arvalid <= 0;
			if (v) s_axi_rready <= 0;
		end
		if (!v) hang();
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, e);
	endtask : rdc

	// cycles up to the next domain tick, and pin rises seen on the way
	task automatic wt(output int n, output int p);
		logic q;
		n = 0;
		p = 0;
		q = pin;
		do begin
			@(negedge clock_i);
			n++;
			if (pin && !q) p++;
			q = pin;
		end while (!ct && n < 3000);
		if (n >= 3000) hang();
	endtask : wt

	initial begin
		int n, p, lo, a1, a2, t;
		logic [1:0]  r;
		logic [31:0] d;
		rst(4'h0, 2'h0, 1'b1);
		rdc(8'h00, 32'hA5);
		rdc(8'h04, 32'h03);
		chk(oeo, 1'b0);
		t = 'hA5;
		for (int k = 0; k < 4; k++) begin
			// small trim steps keep the oscillator stable; no memory write is under way
			while (t != tv[k]) begin
				t = (tv[k] > t + 32) ? t + 32 : (tv[k] + 32 < t) ? t - 32 : tv[k];
				wr(8'h00, 32'(t), r);
			end
			chk(rank, tr[k]);
		end
		strb <= 4'h0;
		wr(8'h00, 32'hE0, r);
		strb <= 4'hF;
		rdc(8'h00, 32'hFF);
		wr(8'h0C, 32'h1, r);
		chk(r, 2'h2);
		rd(8'h0C, d, r);
		chk(d, 32'h0);
		chk(r, 2'h2);
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			rst(4'(ts[k]), 2'(tu[k]), 1'b0);
			wt(n, p);
			lo = (13 * tp[k] > td[k]) ? 13 * tp[k] : td[k];
			chk(n >= lo && n <= lo + 2 * tp[k] + 8, 1);
			chk({it, at, mt}, 3'h7);
			wt(n, p);
			chk(n, tp[k]);
			rdc(8'h08, (ts[k] << 4) + ((ts[k] != 1 && tu[k] == 3) ? 5 : 1));
		end
		a1 = 0;
		a2 = 0;
		for (int k = 0; k < 160; k++) begin
			@(negedge clock_i);
			a1 += nt;
			a2 += plt;
		end
		chk(a1, 20);
		chk(a2, 40);
		$display("test start-up done");
		rst(4'h0, 2'h0, 1'b0);
		wt(n, p);
		@(posedge clock_i);
		pd <= 1;
		repeat (8) @(posedge clock_i);
		a1 = 0;
		for (int k = 0; k < 40; k++) begin
			@(negedge clock_i);
			a1 += ct;
		end
		chk(a1, 0);
		rdc(8'h08, 32'h02);
		@(posedge clock_i);
		pd <= 0;
		wt(n, p);
		chk(n >= 20 && n <= 40, 1);
		$display("test sleep done");
		chk(oeo, 1'b1);
		for (int k = 0; k < 4; k++) begin
			wr(8'h04, 32'h80, r);
			wr(8'h04, pc[k], r);
			rdc(8'h04, pc[k]);
			wt(n, p);
			wt(n, p);
			chk(n, 4 << (pc[k] > 8 ? 8 : pc[k]));
			chk(p, 1);
		end
		wr(8'h04, 32'h81, r);
		wr(8'h04, 32'h02, r);
		rdc(8'h04, 32'h09);
		wr(8'h04, 32'h80, r);
		repeat (8) @(posedge clock_i);
		wr(8'h04, 32'h02, r);
		rdc(8'h04, 32'h09);
		$display("test prescaler done");
		print_verdict();
	end
endmodule : test_system_clock_source_select

`default_nettype wire
